// ==== dv/dacmc_host.sv ====
// Host model that drives the control word port and the word clock pin.
`timescale 1ns/1ns
`default_nettype none
module dacmc_host (
  input  wire logic            core_clk,      // System clock.
  input  wire logic            rd_valid,      // Read answer strobe.
  input  wire logic      [7:0] rd_data,       // Read answer data.
  output logic                 cmd_valid,     // Control word strobe.
  output dacmc_pkg::dacmc_cmd_t cmd_word,     // Control word.
  output logic                 lr_word_clock  // Word clock pin.
);
  import dacmc_pkg::*;

  initial begin
    cmd_valid     = 1'b0;
    cmd_word      = 16'h0000;
    lr_word_clock = 1'b0;
  end

  // Released word lines are inverted so stale data never looks valid.
  task automatic access(input logic rnw, input logic [6:0] idx,
                        input logic [7:0] data);
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_word  <= '{rnw: rnw, idx: idx, data: data};
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    cmd_word  <= dacmc_cmd_t'(~cmd_word);
  endtask

  task automatic read(input logic [6:0] idx, output logic [7:0] data,
                      output logic ok);
    ok   = 1'b0;
    data = 8'h00;
    access(1'b1, idx, 8'h00);
    for (int i = 0; i < 4 && ok !== 1'b1; i++) begin
      @(posedge core_clk);
      if (rd_valid === 1'b1) begin
        ok   = 1'b1;
        data = rd_data;
      end
    end
  endtask

  // Word clock counts are kept a multiple of eight by callers so the step divider
  // phase is the same at every rate change.
  task automatic word_clocks(input int n);
    repeat (n) begin
      @(posedge core_clk);
      lr_word_clock <= 1'b1;
      repeat (4) @(posedge core_clk);
      lr_word_clock <= 1'b0;
      repeat (3) @(posedge core_clk);
    end
    repeat (8) @(posedge core_clk);
  endtask
endmodule
`default_nettype wire

// ==== dv/dacmc_regs_test.sv ====
// Self-checking testbench of the converter mode control register bank.
`timescale 1ns/1ns
`default_nettype none
module dacmc_regs_test;
  import dacmc_pkg::*;

  logic                  core_clk;
  logic                  sys_rst;
  logic                  cmd_valid;
  dacmc_cmd_t            cmd_word;
  logic                  zero_flag_l;
  logic                  zero_flag_r;
  logic            [4:0] slot_id_in;
  logic                  lr_word_clock;
  logic                  rd_valid;
  logic            [7:0] rd_data;
  dacmc_cfg_t            cfg;
  logic       [1:0][7:0] ch_level;
  logic       [1:0][7:0] ch_atten_steps;
  logic            [1:0] ch_muted;
  logic                  soft_reset_pulse;
  logic            [7:0] exp_lvl;
  int                    pulses;
  int                    fail_count = 0;
  int                    n_tests = 0;

  dacmc_regs u_dacmc_regs (
    .core_clk(core_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
    .cmd_word(cmd_word), .zero_flag_l(zero_flag_l),
    .zero_flag_r(zero_flag_r), .slot_id_in(slot_id_in),
    .lr_word_clock(lr_word_clock), .rd_valid(rd_valid), .rd_data(rd_data),
    .cfg(cfg), .ch_level(ch_level), .ch_atten_steps(ch_atten_steps),
    .ch_muted(ch_muted), .soft_reset_pulse(soft_reset_pulse));

  dacmc_host u_dacmc_host (
    .core_clk(core_clk), .rd_valid(rd_valid), .rd_data(rd_data),
    .cmd_valid(cmd_valid), .cmd_word(cmd_word),
    .lr_word_clock(lr_word_clock));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [6:0] idx, input logic [7:0] data);
    u_dacmc_host.access(1'b0, idx, data);
  endtask

  // A read that never answers ends the run as a mismatch.
  task automatic rd_chk(input logic [6:0] idx, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    u_dacmc_host.read(idx, d, ok);
    if (ok !== 1'b1) begin
      fail_count++;
      report_and_stop();
    end else begin
      check(d, exp);
    end
  endtask

  initial begin
    repeat (100000) @(posedge core_clk);
    fail_count++;
    report_and_stop();
  end

  initial begin
    sys_rst     = 1'b1;
    zero_flag_l = 1'b1;
    zero_flag_r = 1'b0;
    slot_id_in  = 5'h0B;
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd_chk(REG_LEFT_ATTEN, 8'hFF);
    rd_chk(REG_RIGHT_ATTEN, 8'hFF);
    rd_chk(REG_FMT_CTL, 8'h50);
    rd_chk(REG_PHASE_CTL, 8'h00);
    rd_chk(REG_MODE_CTL, 8'h00);
    rd_chk(REG_ZERO_CTL, 8'h01);
    rd_chk(REG_ZERO_FLAGS, 8'h01);
    rd_chk(REG_SLOT_ID, 8'h0B);
    wr(REG_RIGHT_ATTEN, 8'hA5);
    rd_chk(REG_RIGHT_ATTEN, 8'hA5);
    rd_chk(REG_LEFT_ATTEN, 8'hFF);
    wr(7'h20, 8'h55);
    rd_chk(7'h20, 8'h00);
    wr(REG_ZERO_FLAGS, 8'hFE);
    wr(REG_SLOT_ID, 8'hFF);
    zero_flag_l <= 1'b0;
    zero_flag_r <= 1'b1;
    rd_chk(REG_ZERO_FLAGS, 8'h02);
    rd_chk(REG_SLOT_ID, 8'h0B);
    wr(REG_MODE_CTL, 8'hBF);
    rd_chk(REG_MODE_CTL, 8'h3F);
    check({2'h0, cfg.fir_rate_sel, cfg.one_bit_stream_mode,
           cfg.filter_bypass, cfg.single_channel_mode,
           cfg.single_channel_pick}, 8'h3F);
    wr(REG_MODE_CTL, 8'h00);
    wr(REG_ZERO_CTL, 8'hFF);
    rd_chk(REG_ZERO_CTL, 8'h07);
    check({5'h00, cfg.stream_zero_pattern_sel,
           cfg.pcm_zero_flag_enable}, 8'h07);
    for (int i = 0; i < 8; i++) begin
      wr(REG_FMT_CTL, {1'b0, 3'(i), 2'(i), 1'(i), 1'b0});
      repeat (2) @(posedge core_clk);
      check(8'(cfg.audio_format_sel), 8'(i));
      check({6'h00, cfg.deemph_rate_sel}, 8'(i % 4));
      check({7'h00, cfg.deemph_enable}, 8'(i % 2));
      rd_chk(REG_FMT_CTL, {1'b0, 3'(i), 2'(i), 1'(i), 1'b0});
    end
    wr(REG_MODE_CTL, 8'h22);
    repeat (2) @(posedge core_clk);
    check({6'h00, cfg.fir_rate_sel}, 8'h02);
    check({6'h00, cfg.oversample_rate_sel}, 8'h00);
    check({6'h00, cfg.fir_perf_sel}, 8'h03);
    check({6'h00, cfg.deemph_rate_sel}, 8'h00);
    wr(REG_MODE_CTL, 8'h00);
    // A code written while the gate is shut must not load when it opens.
    wr(REG_FMT_CTL, 8'h50);
    wr(REG_LEFT_ATTEN, 8'h80);
    wr(REG_FMT_CTL, 8'hD0);
    u_dacmc_host.word_clocks(8);
    check(ch_level[0], 8'hFF);
    rd_chk(REG_LEFT_ATTEN, 8'h80);
    wr(REG_LEFT_ATTEN, 8'h80);
    exp_lvl = 8'hFF;
    for (int r = 0; r < 4; r++) begin
      wr(REG_PHASE_CTL, {1'b1, 2'(r), 5'h00});
      u_dacmc_host.word_clocks(8);
      exp_lvl = exp_lvl - 8'(8 >> r);
      check(ch_level[0], exp_lvl);
      check(ch_atten_steps[0], 8'hFF - exp_lvl);
      check(ch_level[1], 8'hFF);
      check({7'h00, cfg.phase_invert}, 8'h01);
    end
    check({6'h00, ch_muted}, 8'h00);
    wr(REG_PHASE_CTL, 8'h1F);
    wr(REG_FMT_CTL, 8'hD1);
    u_dacmc_host.word_clocks(256);
    check({3'h0, cfg.output_disable, cfg.mode_data_out_enable,
           cfg.bypass_stereo_sel, cfg.rolloff_sel,
           cfg.zero_hold_mute_enable}, 8'h1F);
    check(ch_level[0], 8'h00);
    check(ch_level[1], 8'h00);
    check({6'h00, ch_muted}, 8'h03);
    wr(REG_FMT_CTL, 8'hD0);
    wr(REG_LEFT_ATTEN, 8'h0F);
    u_dacmc_host.word_clocks(16);
    check(ch_level[0], 8'h0F);
    check(ch_atten_steps[0], 8'hF0);
    check({7'h00, ch_muted[0]}, 8'h00);
    wr(REG_LEFT_ATTEN, 8'h0E);
    u_dacmc_host.word_clocks(8);
    check({7'h00, ch_muted[0]}, 8'h01);
    wr(REG_PHASE_CTL, 8'hE0);
    wr(REG_MODE_CTL, 8'h40);
    pulses = 0;
    repeat (6) begin
      @(negedge core_clk);
      if (soft_reset_pulse === 1'b1)
        pulses++;
    end
    check(8'(pulses), 8'h01);
    rd_chk(REG_PHASE_CTL, 8'h00);
    rd_chk(REG_FMT_CTL, 8'h50);
    rd_chk(REG_LEFT_ATTEN, 8'hFF);
    check(ch_level[0], 8'hFF);
    report_and_stop();
  end
endmodule
`default_nettype wire

// ==== rtl/dacmc_pkg.sv ====
// Constants and types shared by the converter mode control register bank.
// Contract
// - Top word bit selects write at 0, read at 1, for registers 16-21.
// - Registers 22 and 23 are read-only; writes never change them.
// - Bits 14 to 8 index the register; bits 7 to 0 carry data.
// - Each channel has its own 8-bit attenuation code, reset to all ones.
// - Codes 15 to 255 give gain of half dB times code minus 255.
// - Codes 0 through 14 mute the channel completely.
// - Shared load gate, reset 0; written codes take effect only while 1.
// - Three-bit format field selects serial format; reset value is 101.
// - Two-bit de-emphasis rate field: off, 48, 44.1, 32 kHz; reset off.
// - In one-bit stream mode the rate field picks FIR performance.
// - In one-bit stream mode the oversampling field picks FIR rate.
// - De-emphasis enable bit, reset 0, switches both channels together.
// - Soft mute ramps both channels to mute in steps at ramp rate.
// - Phase reversal bit, reset 0, inverts both channel outputs when set.
// - Ramp rate field steps every 1, 2, 4 or 8 word clock periods.
// - Writing 1 to system reset bit yields one internal reset pulse.
package dacmc_pkg;

  typedef struct packed {
    logic       rnw;
    logic [6:0] idx;
    logic [7:0] data;
  } dacmc_cmd_t;

  localparam logic [6:0] REG_LEFT_ATTEN  = 7'h10;
  localparam logic [6:0] REG_RIGHT_ATTEN = 7'h11;
  localparam logic [6:0] REG_FMT_CTL     = 7'h12;
  localparam logic [6:0] REG_PHASE_CTL   = 7'h13;
  localparam logic [6:0] REG_MODE_CTL    = 7'h14;
  localparam logic [6:0] REG_ZERO_CTL    = 7'h15;
  localparam logic [6:0] REG_ZERO_FLAGS  = 7'h16;
  localparam logic [6:0] REG_SLOT_ID     = 7'h17;

  localparam logic [7:0] ATTEN_RESET     = 8'hFF;
  localparam logic [7:0] ATTEN_MUTE_MAX  = 8'h0E;
  localparam logic [7:0] ATTEN_FLOOR     = 8'h00;
  localparam logic [7:0] FMT_CTL_RESET   = 8'h50;
  localparam logic [7:0] PHASE_CTL_RESET = 8'h00;
  localparam logic [7:0] MODE_CTL_RESET  = 8'h00;
  localparam logic [7:0] ZERO_CTL_RESET  = 8'h01;
  localparam logic [7:0] MODE_CTL_MASK   = 8'h3F;
  localparam logic [7:0] ZERO_CTL_MASK   = 8'h07;

  localparam int LOAD_GATE_POS = 7;
  localparam int FMT_HI        = 6;
  localparam int FMT_LO        = 4;
  localparam int DMF_HI        = 3;
  localparam int DMF_LO        = 2;
  localparam int DME_POS       = 1;
  localparam int MUTE_POS      = 0;
  localparam int REV_POS       = 7;
  localparam int ATS_HI        = 6;
  localparam int ATS_LO        = 5;
  localparam int OPE_POS       = 4;
  localparam int MODE_DATA_OUT_ENABLE_POS      = 3;
  localparam int BYPASS_STEREO_SEL_POS      = 2;
  localparam int FLT_POS       = 1;
  localparam int ZERO_HOLD_MUTE_ENABLE_POS      = 0;
  localparam int SOFT_SYSTEM_RESET_POS      = 6;
  localparam int ONEBIT_POS    = 5;
  localparam int BYPASS_POS    = 4;
  localparam int SINGLE_CHANNEL_MODE_POS      = 3;
  localparam int SINGLE_CHANNEL_PICK_POS      = 2;
  localparam int OS_HI         = 1;
  localparam int OS_LO         = 0;
  localparam int DZ_HI         = 2;
  localparam int DZ_LO         = 1;
  localparam int PCM_ZERO_FLAG_ENABLE_POS      = 0;

  typedef enum logic [2:0] {
    FMT_RJ16 = 3'h0, FMT_RJ20 = 3'h1, FMT_RJ24 = 3'h2, FMT_LJ24 = 3'h3,
    FMT_I2S16 = 3'h4, FMT_I2S24 = 3'h5, FMT_RSV6 = 3'h6, FMT_RSV7 = 3'h7
  } dacmc_fmt_t;

  typedef struct packed {
    dacmc_fmt_t audio_format_sel;
    logic [1:0] deemph_rate_sel;
    logic       deemph_enable;
    logic [1:0] fir_perf_sel;
    logic [1:0] oversample_rate_sel;
    logic [1:0] fir_rate_sel;
    logic       phase_invert;
    logic       output_disable;
    logic       mode_data_out_enable;
    logic       bypass_stereo_sel;
    logic       rolloff_sel;
    logic       zero_hold_mute_enable;
    logic       one_bit_stream_mode;
    logic       filter_bypass;
    logic       single_channel_mode;
    logic       single_channel_pick;
    logic [1:0] stream_zero_pattern_sel;
    logic       pcm_zero_flag_enable;
  } dacmc_cfg_t;

  localparam dacmc_cfg_t CFG_RESET = '{
    audio_format_sel: FMT_I2S24, pcm_zero_flag_enable: 1'b1, default: '0};

endpackage

// ==== rtl/dacmc_ramp.sv ====
// One channel attenuator that walks its level toward a target code.
`timescale 1ns/1ns
`default_nettype none
module dacmc_ramp (
  input  wire logic       core_clk,    // System clock.
  input  wire logic       sys_rst,     // Asynchronous reset, active high.
  input  wire logic       soft_rst,    // Internal reset pulse.
  input  wire logic       step_tick,   // Step enable.
  input  wire logic [7:0] target,      // Code to reach.
  output logic      [7:0] level,       // Effective attenuation code.
  output logic      [7:0] atten_steps, // Half-dB steps below full scale.
  output logic            muted        // Channel fully muted.
);
  import dacmc_pkg::*;

  logic [7:0] nxt_level;
  logic [7:0] nxt_steps;
  logic       nxt_muted;

  always_comb begin
    nxt_level = level;
    if (soft_rst) begin
      nxt_level = ATTEN_RESET;
    end else if (step_tick && level < target) begin
      nxt_level = level + 8'h01;
    end else if (step_tick && level > target) begin
      nxt_level = level - 8'h01;
    end
    nxt_steps = ATTEN_RESET - nxt_level;
    nxt_muted = nxt_level <= ATTEN_MUTE_MAX;
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      level       <= ATTEN_RESET;
      atten_steps <= 8'h00;
      muted       <= 1'b0;
    end else begin
      level       <= nxt_level;
      atten_steps <= nxt_steps;
      muted       <= nxt_muted;
    end
  end

  property p_ramp_hold;
    @(posedge core_clk) disable iff (sys_rst)
    !step_tick && !soft_rst |=> $stable(level);
  endproperty
  a_ramp_hold: assert property (p_ramp_hold)
    else $error("Level moved without a step enable.");

  property p_ramp_unit;
    @(posedge core_clk) disable iff (sys_rst)
    step_tick && !soft_rst |=>
      (level == $past(level) + 8'h01) || (level == $past(level) - 8'h01) ||
      (level == $past(level));
  endproperty
  a_ramp_unit: assert property (p_ramp_unit)
    else $error("Level jumped by more than one step.");

  property p_mute_gain;
    @(posedge core_clk) disable iff (sys_rst)
    muted == (level <= ATTEN_MUTE_MAX)
      && atten_steps == 8'(ATTEN_RESET - level);
  endproperty
  a_mute_gain: assert property (p_mute_gain)
    else $error("Mute flag disagrees with level.");

endmodule
`default_nettype wire

// ==== rtl/dacmc_regs.sv ====
// Mode control register bank of the stereo converter.
`timescale 1ns/1ns
`default_nettype none
module dacmc_regs (
  input  wire logic                  core_clk,      // System clock.
  input  wire logic                  sys_rst,       // Async reset, high.
  input  wire logic                  cmd_valid,     // Control word strobe.
  input  wire dacmc_pkg::dacmc_cmd_t cmd_word,      // Control word.
  input  wire logic                  zero_flag_l,   // Left zero detected.
  input  wire logic                  zero_flag_r,   // Right zero detected.
  input  wire logic            [4:0] slot_id_in,    // Slot identifier.
  input  wire logic                  lr_word_clock, // Word clock pin.
  output logic                       rd_valid,      // Read answer strobe.
  output logic                 [7:0] rd_data,       // Read answer data.
  output dacmc_pkg::dacmc_cfg_t      cfg,           // Decoded settings.
  output logic            [1:0][7:0] ch_level,      // Effective codes.
  output logic            [1:0][7:0] ch_atten_steps, // Half-dB steps.
  output logic                 [1:0] ch_muted,      // Channel muted.
  output logic                       soft_reset_pulse // Internal reset.
);
  import dacmc_pkg::*;

  logic [1:0][7:0] code_ff;
  logic [1:0][7:0] nxt_code;
  logic [1:0][7:0] tgt_ff;
  logic [1:0][7:0] nxt_tgt;
  logic [1:0][7:0] ramp_target;
  logic      [7:0] fmt_ctl_ff;
  logic      [7:0] nxt_fmt_ctl;
  logic      [7:0] phase_ctl_ff;
  logic      [7:0] nxt_phase_ctl;
  logic      [7:0] mode_ctl_ff;
  logic      [7:0] nxt_mode_ctl;
  logic      [7:0] zero_ctl_ff;
  logic      [7:0] nxt_zero_ctl;
  logic            nxt_soft_system_reset;
  logic            nxt_rd_valid;
  logic      [7:0] nxt_rd_data;
  dacmc_cfg_t      nxt_cfg;
  logic            wr_en;
  logic            rd_en;
  logic            one_bit;
  logic            step_tick;

  // Writes during the internal reset pulse are dropped so defaults win.
  always_comb begin
    wr_en         = cmd_valid && !cmd_word.rnw && !soft_reset_pulse;
    rd_en         = cmd_valid && cmd_word.rnw;
    nxt_code      = code_ff;
    nxt_tgt       = tgt_ff;
    nxt_fmt_ctl   = fmt_ctl_ff;
    nxt_phase_ctl = phase_ctl_ff;
    nxt_mode_ctl  = mode_ctl_ff;
    nxt_zero_ctl  = zero_ctl_ff;
    nxt_soft_system_reset      = 1'b0;
    if (soft_reset_pulse) begin
      nxt_code      = {ATTEN_RESET, ATTEN_RESET};
      nxt_tgt       = {ATTEN_RESET, ATTEN_RESET};
      nxt_fmt_ctl   = FMT_CTL_RESET;
      nxt_phase_ctl = PHASE_CTL_RESET;
      nxt_mode_ctl  = MODE_CTL_RESET;
      nxt_zero_ctl  = ZERO_CTL_RESET;
    end else if (wr_en) begin
      for (int ch = 0; ch < 2; ch++) begin
        if (cmd_word.idx == 7'(REG_LEFT_ATTEN + ch)) begin
          nxt_code[ch] = cmd_word.data;
          if (fmt_ctl_ff[LOAD_GATE_POS]) begin
            nxt_tgt[ch] = cmd_word.data;
          end
        end
      end
      case (cmd_word.idx)
        REG_FMT_CTL: begin
          nxt_fmt_ctl = cmd_word.data;
        end
        REG_PHASE_CTL: begin
          nxt_phase_ctl = cmd_word.data;
        end
        REG_MODE_CTL: begin
          nxt_mode_ctl = cmd_word.data & MODE_CTL_MASK;
          nxt_soft_system_reset     = cmd_word.data[SOFT_SYSTEM_RESET_POS];
        end
        REG_ZERO_CTL: begin
          nxt_zero_ctl = cmd_word.data & ZERO_CTL_MASK;
        end
        default: begin
          nxt_soft_system_reset = 1'b0;
        end
      endcase
    end
  end

  // Unmapped indexes answer zero so the host never waits on a read.
  always_comb begin
    nxt_rd_valid = rd_en;
    nxt_rd_data  = rd_data;
    if (rd_en) begin
      case (cmd_word.idx)
        REG_LEFT_ATTEN:  nxt_rd_data = code_ff[0];
        REG_RIGHT_ATTEN: nxt_rd_data = code_ff[1];
        REG_FMT_CTL:     nxt_rd_data = fmt_ctl_ff;
        REG_PHASE_CTL:   nxt_rd_data = phase_ctl_ff;
        REG_MODE_CTL:    nxt_rd_data = mode_ctl_ff & MODE_CTL_MASK;
        REG_ZERO_CTL:    nxt_rd_data = zero_ctl_ff & ZERO_CTL_MASK;
        REG_ZERO_FLAGS:  nxt_rd_data = {6'h00, zero_flag_r, zero_flag_l};
        REG_SLOT_ID:     nxt_rd_data = {3'h0, slot_id_in};
        default:         nxt_rd_data = 8'h00;
      endcase
    end
  end

  // In one-bit stream mode two fields are steered to the FIR filter.
  always_comb begin
    one_bit                         = mode_ctl_ff[ONEBIT_POS];
    nxt_cfg                         = CFG_RESET;
    nxt_cfg.audio_format_sel        =
      dacmc_fmt_t'(fmt_ctl_ff[FMT_HI:FMT_LO]);
    nxt_cfg.deemph_rate_sel         =
      one_bit ? 2'h0 : fmt_ctl_ff[DMF_HI:DMF_LO];
    nxt_cfg.deemph_enable           = fmt_ctl_ff[DME_POS];
    nxt_cfg.fir_perf_sel            =
      one_bit ? fmt_ctl_ff[DMF_HI:DMF_LO] : 2'h0;
    nxt_cfg.oversample_rate_sel     =
      one_bit ? 2'h0 : mode_ctl_ff[OS_HI:OS_LO];
    nxt_cfg.fir_rate_sel            =
      one_bit ? mode_ctl_ff[OS_HI:OS_LO] : 2'h0;
    nxt_cfg.phase_invert            = phase_ctl_ff[REV_POS];
    nxt_cfg.output_disable          = phase_ctl_ff[OPE_POS];
    nxt_cfg.mode_data_out_enable    = phase_ctl_ff[MODE_DATA_OUT_ENABLE_POS];
    nxt_cfg.bypass_stereo_sel       = phase_ctl_ff[BYPASS_STEREO_SEL_POS];
    nxt_cfg.rolloff_sel             = phase_ctl_ff[FLT_POS];
    nxt_cfg.zero_hold_mute_enable   = phase_ctl_ff[ZERO_HOLD_MUTE_ENABLE_POS];
    nxt_cfg.one_bit_stream_mode     = one_bit;
    nxt_cfg.filter_bypass           = mode_ctl_ff[BYPASS_POS];
    nxt_cfg.single_channel_mode     = mode_ctl_ff[SINGLE_CHANNEL_MODE_POS];
    nxt_cfg.single_channel_pick     = mode_ctl_ff[SINGLE_CHANNEL_PICK_POS];
    nxt_cfg.stream_zero_pattern_sel = zero_ctl_ff[DZ_HI:DZ_LO];
    nxt_cfg.pcm_zero_flag_enable    = zero_ctl_ff[PCM_ZERO_FLAG_ENABLE_POS];
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      code_ff          <= {ATTEN_RESET, ATTEN_RESET};
      tgt_ff           <= {ATTEN_RESET, ATTEN_RESET};
      fmt_ctl_ff       <= FMT_CTL_RESET;
      phase_ctl_ff     <= PHASE_CTL_RESET;
      mode_ctl_ff      <= MODE_CTL_RESET;
      zero_ctl_ff      <= ZERO_CTL_RESET;
      soft_reset_pulse <= 1'b0;
      rd_valid         <= 1'b0;
      rd_data          <= 8'h00;
      cfg              <= CFG_RESET;
    end else begin
      code_ff          <= nxt_code;
      tgt_ff           <= nxt_tgt;
      fmt_ctl_ff       <= nxt_fmt_ctl;
      phase_ctl_ff     <= nxt_phase_ctl;
      mode_ctl_ff      <= nxt_mode_ctl;
      zero_ctl_ff      <= nxt_zero_ctl;
      soft_reset_pulse <= nxt_soft_system_reset;
      rd_valid         <= nxt_rd_valid;
      rd_data          <= nxt_rd_data;
      cfg              <= nxt_cfg;
    end
  end

  dacmc_tick u_tick (
    .core_clk      (core_clk),
    .sys_rst       (sys_rst),
    .lr_word_clock (lr_word_clock),
    .rate_sel      (phase_ctl_ff[ATS_HI:ATS_LO]),
    .step_tick     (step_tick)
  );

  // Soft mute reuses the level ramp, so it fades at the same step rate.
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    assign ramp_target[ch] =
      fmt_ctl_ff[MUTE_POS] ? ATTEN_FLOOR : tgt_ff[ch];
    dacmc_ramp u_ramp (
      .core_clk    (core_clk),
      .sys_rst     (sys_rst),
      .soft_rst    (soft_reset_pulse),
      .step_tick   (step_tick),
      .target      (ramp_target[ch]),
      .level       (ch_level[ch]),
      .atten_steps (ch_atten_steps[ch]),
      .muted       (ch_muted[ch])
    );
  end

  property p_read_answer;
    @(posedge core_clk) disable iff (sys_rst)
    cmd_valid && cmd_word.rnw |=> rd_valid;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("Read word got no answer.");

  property p_write_silent;
    @(posedge core_clk) disable iff (sys_rst)
    cmd_valid && !cmd_word.rnw |=> !rd_valid;
  endproperty
  a_write_silent: assert property (p_write_silent)
    else $error("Write word produced a read answer.");

  property p_ro_keep;
    @(posedge core_clk) disable iff (sys_rst)
    wr_en && (cmd_word.idx == REG_ZERO_FLAGS || cmd_word.idx == REG_SLOT_ID)
      |=> $stable(fmt_ctl_ff) && $stable(mode_ctl_ff) && $stable(code_ff)
          && !soft_reset_pulse;
  endproperty
  a_ro_keep: assert property (p_ro_keep)
    else $error("Write to read-only register changed state.");

  property p_idx_write;
    @(posedge core_clk) disable iff (sys_rst)
    wr_en && cmd_word.idx == REG_RIGHT_ATTEN
      |=> code_ff[1] == $past(cmd_word.data) && $stable(code_ff[0]);
  endproperty
  a_idx_write: assert property (p_idx_write)
    else $error("Right code not stored from its index.");

  property p_gate_closed;
    @(posedge core_clk) disable iff (sys_rst)
    wr_en && cmd_word.idx == REG_LEFT_ATTEN && !fmt_ctl_ff[LOAD_GATE_POS]
      |=> $stable(tgt_ff[0]);
  endproperty
  a_gate_closed: assert property (p_gate_closed)
    else $error("Closed load gate let a code through.");

  property p_gate_open;
    @(posedge core_clk) disable iff (sys_rst)
    wr_en && cmd_word.idx == REG_LEFT_ATTEN && fmt_ctl_ff[LOAD_GATE_POS]
      |=> tgt_ff[0] == $past(cmd_word.data);
  endproperty
  a_gate_open: assert property (p_gate_open)
    else $error("Open load gate did not load the code.");

  property p_reserved_zero;
    @(posedge core_clk) disable iff (sys_rst)
    rd_en && cmd_word.idx == REG_ZERO_CTL |=> rd_data[7:3] == 5'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("Reserved bits read back nonzero.");

  property p_soft_system_reset_once;
    @(posedge core_clk) disable iff (sys_rst)
    soft_reset_pulse |=> !soft_reset_pulse
      && fmt_ctl_ff == FMT_CTL_RESET && code_ff[0] == ATTEN_RESET;
  endproperty
  a_soft_system_reset_once: assert property (p_soft_system_reset_once)
    else $error("Internal reset not a single restoring pulse.");

  property p_fir_perf;
    @(posedge core_clk) disable iff (sys_rst)
    mode_ctl_ff[ONEBIT_POS] |=>
      cfg.fir_perf_sel == $past(fmt_ctl_ff[DMF_HI:DMF_LO])
      && cfg.deemph_rate_sel == 2'h0;
  endproperty
  a_fir_perf: assert property (p_fir_perf)
    else $error("Rate field not steered to FIR filter.");

  property p_fir_rate;
    @(posedge core_clk) disable iff (sys_rst)
    mode_ctl_ff[ONEBIT_POS] |=>
      cfg.fir_rate_sel == $past(mode_ctl_ff[OS_HI:OS_LO]);
  endproperty
  a_fir_rate: assert property (p_fir_rate)
    else $error("Oversampling field not steered to FIR filter.");

  property p_fmt_write;
    @(posedge core_clk) disable iff (sys_rst)
    wr_en && cmd_word.idx == REG_FMT_CTL
      |=> fmt_ctl_ff == $past(cmd_word.data);
  endproperty
  a_fmt_write: assert property (p_fmt_write)
    else $error("Format register write was not performed.");

  property p_mode_rsv;
    @(posedge core_clk) disable iff (sys_rst)
    rd_en && cmd_word.idx == REG_MODE_CTL |=> rd_data[7:6] == 2'h0;
  endproperty
  a_mode_rsv: assert property (p_mode_rsv)
    else $error("Reserved or reset bit read back nonzero.");

  property p_mute_walk;
    @(posedge core_clk) disable iff (sys_rst)
    fmt_ctl_ff[MUTE_POS] && step_tick && !soft_reset_pulse
      && ch_level[0] != ATTEN_FLOOR
      |=> ch_level[0] == $past(ch_level[0]) - 8'h01;
  endproperty
  a_mute_walk: assert property (p_mute_walk)
    else $error("Soft mute did not step the level down.");

  c_soft_mute: cover property (@(posedge core_clk) disable iff (sys_rst)
    fmt_ctl_ff[MUTE_POS] && ch_muted == 2'h3);
  c_gated_write: cover property (@(posedge core_clk) disable iff (sys_rst)
    wr_en && cmd_word.idx == REG_LEFT_ATTEN && fmt_ctl_ff[LOAD_GATE_POS]);
  c_soft_reset: cover property (@(posedge core_clk) disable iff (sys_rst)
    soft_reset_pulse);
  c_ramp_step: cover property (@(posedge core_clk) disable iff (sys_rst)
    step_tick && ch_level[0] != tgt_ff[0]);

endmodule
`default_nettype wire

// ==== rtl/dacmc_tick.sv ====
// Word clock synchroniser and ramp step divider.
`timescale 1ns/1ns
`default_nettype none
module dacmc_tick (
  input  wire logic       core_clk,      // System clock.
  input  wire logic       sys_rst,       // Asynchronous reset, active high.
  input  wire logic       lr_word_clock, // Word clock pin, asynchronous.
  input  wire logic [1:0] rate_sel,      // Ramp rate field.
  output logic            step_tick      // One-cycle step enable.
);
  import dacmc_pkg::*;

  logic       meta_ff;
  logic       sync_ff;
  logic       prev_ff;
  logic [2:0] div_ff;
  logic [2:0] nxt_div;
  logic       nxt_tick;
  logic [2:0] div_mask;

  // Rising word clock edges are counted; a step fires on each edge that finds the low bits at zero.
  always_comb begin
    case (rate_sel)
      2'h0:    div_mask = 3'h0;
      2'h1:    div_mask = 3'h1;
      2'h2:    div_mask = 3'h3;
      default: div_mask = 3'h7;
    endcase
    nxt_div  = div_ff;
    nxt_tick = 1'b0;
    if (sync_ff && !prev_ff) begin
      nxt_div  = div_ff + 3'h1;
      nxt_tick = (div_ff & div_mask) == 3'h0;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_ff   <= 1'b0;
      sync_ff   <= 1'b0;
      prev_ff   <= 1'b0;
      div_ff    <= 3'h0;
      step_tick <= 1'b0;
    end else begin
      meta_ff   <= lr_word_clock;
      sync_ff   <= meta_ff;
      prev_ff   <= sync_ff;
      div_ff    <= nxt_div;
      step_tick <= nxt_tick;
    end
  end

endmodule
`default_nettype wire
